// *** hdl/uss_baud.sv ***
// baud tick generator: one tick per (1 - divisor) host clock edges
// assumes host_edge is a one-cycle pulse already synchronised to clk
`timescale 1ns/10ps
`default_nettype none
module uss_baud #(
   parameter int W = 16
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic en,
   input wire logic host_edge,
   input wire logic [W-1:0] div,
   output logic tick
);
   logic [W-1:0] cnt_q;
   wire cnt_wrap = (cnt_q == '0);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= '0;
         tick <= 1'b0;
      end else if (ce) begin
         tick <= en && host_edge && cnt_wrap;
         if (!en) begin
            cnt_q <= div;
         end else if (host_edge) begin
            cnt_q <= cnt_wrap ? div : cnt_q + 1'b1;
         end
      end
   end
endmodule : uss_baud
`default_nettype wire

// *** hdl/uss_pkg.sv ***
// constants, register map and carrier types of the serial status/control uart
// assumes a byte-wide register port and a continuous host bit clock on a pin
package uss_pkg;
   localparam logic [7:0] ADDR_DIV_LO = 8'h0A;
   localparam logic [7:0] ADDR_DIV_HI = 8'h0B;
   localparam logic [7:0] ADDR_DATA = 8'h0C;
   localparam logic [7:0] ADDR_STAT = 8'h0D;
   localparam logic [7:0] ADDR_IEN = 8'h0E;
   localparam logic [7:0] ADDR_MODE = 8'h0F;

   localparam int IEN_TX = 0;
   localparam int IEN_RX = 1;
   localparam int MODE_EN = 0;

   localparam logic [15:0] DIV_RST = 16'hFFFF;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [7:0] BYTE_ONES = 8'hFF;
   localparam logic [3:0] PH_MID = 4'h7;
   localparam logic [3:0] PH_LAST = 4'hF;
   localparam logic [3:0] PH_ZERO = 4'h0;
   localparam logic [2:0] IDX_ZERO = 3'h0;
   localparam logic [2:0] LAST_IDX_BASE = 3'h4;
   localparam logic [1:0] LEN_FULL = 2'h3;

   localparam int PIN_RXD = 0;
   localparam int PIN_CTS = 1;
   localparam int PIN_DSR = 2;
   localparam int PIN_DCD = 3;
   localparam int PIN_HCLK = 4;
   localparam int NPIN = 5;

   // written layout of the status/control register, bit 5 down to bit 0
   typedef struct packed {
      logic two_stop;
      logic odd;
      logic par_en;
      logic [1:0] len;
      logic brk;
   } uss_fmt_s;

   // read layout of the status/control register, bit 7 down to bit 0
   typedef struct packed {
      logic perr;
      logic ovfr;
      logic rx_wait;
      logic tx_busy;
      logic thr_empty;
      logic dcd;
      logic dsr;
      logic cts;
   } uss_stat_s;

   localparam uss_fmt_s FMT_RST = '0;

   typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} uss_tx_e;
   typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} uss_rx_e;
endpackage : uss_pkg

// *** hdl/uss_uart.sv ***
// single-channel uart with combined status/control register
// assumes a byte register port on CLK; line pins and host clock are asynchronous
// How it works
// - bit0 reads CTS, write sends break
// - bits 1,2 read DSR and DCD
// - written bits 1,2 select character length
// - written bit3 enables parity both directions
// - written bit4 odd parity, else even
// - written bit5 two stop bits, else one
// - holding byte sent, empty after stop
// - read bit3 empty, bit4 transmitter busy
// - interrupt when holding register becomes empty
// - status read clears pending interrupt
// - received character stored, bit5 data waiting
// - interrupt on every received character
// - bit6 overrun/framing, bit7 parity error
// - uart runs only while mode bit0 set
// - divisor low byte reg 10, high 11
// - divisor counts host clock, two's complement
`timescale 1ns/10ps
`default_nettype none
module uss_uart #(
   parameter int DIV_W = 16
) (
   input wire logic CLK,
   input wire logic RESETN,
   input wire logic CE,
   input wire logic [7:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [7:0] RDATA,
   input wire logic HOST_CLK,
   input wire logic RXD,
   input wire logic CTS,
   input wire logic DSR,
   input wire logic DCD,
   output logic TXD,
   output logic IRQ
);
   // pin synchronisers
   wire [uss_pkg::NPIN-1:0] pin_raw = {HOST_CLK, DCD, DSR, CTS, RXD};
   logic [uss_pkg::NPIN-1:0] pin_m_q;
   logic [uss_pkg::NPIN-1:0] pin_s_q;
   genvar gi;
   generate
      for (gi = 0; gi < uss_pkg::NPIN; gi++) begin : g_sync
         always_ff @(posedge CLK or negedge RESETN) begin
            if (!RESETN) begin
               pin_m_q[gi] <= 1'b1;
               pin_s_q[gi] <= 1'b1;
            end else if (CE) begin
               pin_m_q[gi] <= pin_raw[gi];
               pin_s_q[gi] <= pin_m_q[gi];
            end
         end
      end
   endgenerate
   logic hclk_prev_q;
   wire host_edge = pin_s_q[uss_pkg::PIN_HCLK] && !hclk_prev_q;
   wire rxd_s = pin_s_q[uss_pkg::PIN_RXD];

   // registers
   uss_pkg::uss_fmt_s fmt_q;
   logic [DIV_W-1:0] div_q;
   logic [1:0] ien_q;
   logic en_q;
   logic [7:0] thr_q;
   logic thr_full_q;
   logic [7:0] rcr_q;
   logic rxw_q;
   logic ovfr_q;
   logic perr_q;
   logic irq_q;
   logic [7:0] rdata_q;
   logic txd_q;

   wire wr_div_lo = WR && (ADDR == uss_pkg::ADDR_DIV_LO);
   wire wr_div_hi = WR && (ADDR == uss_pkg::ADDR_DIV_HI);
   wire wr_thr = WR && (ADDR == uss_pkg::ADDR_DATA);
   wire wr_fmt = WR && (ADDR == uss_pkg::ADDR_STAT);
   wire wr_ien = WR && (ADDR == uss_pkg::ADDR_IEN);
   wire wr_mode = WR && (ADDR == uss_pkg::ADDR_MODE);
   wire rd_rcr = RD && (ADDR == uss_pkg::ADDR_DATA);
   wire rd_stat = RD && (ADDR == uss_pkg::ADDR_STAT);

   // tick source
   logic tick;
   uss_baud #(.W(DIV_W)) u_baud (
      .clk(CLK),
      .rst_n(RESETN),
      .ce(CE),
      .en(en_q),
      .host_edge(host_edge),
      .div(div_q),
      .tick(tick)
   );

   // shared framing
   wire [7:0] data_mask = uss_pkg::BYTE_ONES >> (uss_pkg::LEN_FULL - fmt_q.len);
   wire [2:0] last_idx = uss_pkg::LAST_IDX_BASE + {1'b0, fmt_q.len};

   // transmitter
   uss_pkg::uss_tx_e tx_st_q;
   logic [3:0] tx_ph_q;
   logic [2:0] tx_idx_q;
   logic [7:0] tx_sh_q;
   logic tx_par_q;
   logic tx_stop2_q;
   wire tx_ph_end = tick && (tx_ph_q == uss_pkg::PH_LAST);
   wire tx_done = (tx_st_q == uss_pkg::TX_STOP) && tx_ph_end && !tx_stop2_q;
   wire tx_bit = fmt_q.brk ? 1'b0 :
      (tx_st_q == uss_pkg::TX_START) ? 1'b0 :
      (tx_st_q == uss_pkg::TX_DATA) ? tx_sh_q[0] :
      (tx_st_q == uss_pkg::TX_PAR) ? tx_par_q : 1'b1;

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         tx_st_q <= uss_pkg::TX_IDLE;
         tx_ph_q <= uss_pkg::PH_ZERO;
         tx_idx_q <= uss_pkg::IDX_ZERO;
         tx_sh_q <= uss_pkg::BYTE_ZERO;
         tx_par_q <= 1'b0;
         tx_stop2_q <= 1'b0;
      end else if (CE) begin
         if (tx_st_q != uss_pkg::TX_IDLE && tick) begin
            tx_ph_q <= tx_ph_q + 1'b1;
         end
         if (!en_q) begin
            tx_st_q <= uss_pkg::TX_IDLE;
         end else begin
            case (tx_st_q)
               uss_pkg::TX_IDLE: if (thr_full_q) begin
                  tx_sh_q <= thr_q;
                  tx_par_q <= ^(thr_q & data_mask) ^ fmt_q.odd;
                  tx_ph_q <= uss_pkg::PH_ZERO;
                  tx_st_q <= uss_pkg::TX_START;
               end
               uss_pkg::TX_START: if (tx_ph_end) begin
                  tx_idx_q <= uss_pkg::IDX_ZERO;
                  tx_st_q <= uss_pkg::TX_DATA;
               end
               uss_pkg::TX_DATA: if (tx_ph_end) begin
                  tx_sh_q <= tx_sh_q >> 1;
                  tx_idx_q <= tx_idx_q + 1'b1;
                  tx_stop2_q <= fmt_q.two_stop;
                  if (tx_idx_q == last_idx) begin
                     tx_st_q <= fmt_q.par_en ? uss_pkg::TX_PAR : uss_pkg::TX_STOP;
                  end
               end
               uss_pkg::TX_PAR: if (tx_ph_end) begin
                  tx_st_q <= uss_pkg::TX_STOP;
               end
               default: if (tx_ph_end) begin
                  tx_stop2_q <= 1'b0;
                  if (!tx_stop2_q) begin
                     tx_st_q <= uss_pkg::TX_IDLE;
                  end
               end
            endcase
         end
      end
   end

   // receiver
   uss_pkg::uss_rx_e rx_st_q;
   logic [3:0] rx_ph_q;
   logic [2:0] rx_idx_q;
   logic [7:0] rx_sh_q;
   logic rx_pbad_q;
   wire rx_at_end = tick && (rx_ph_q == uss_pkg::PH_LAST);
   wire rx_done = en_q && (rx_st_q == uss_pkg::RX_STOP) && rx_at_end;

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         rx_st_q <= uss_pkg::RX_IDLE;
         rx_ph_q <= uss_pkg::PH_ZERO;
         rx_idx_q <= uss_pkg::IDX_ZERO;
         rx_sh_q <= uss_pkg::BYTE_ZERO;
         rx_pbad_q <= 1'b0;
      end else if (CE) begin
         if (rx_st_q != uss_pkg::RX_IDLE && tick) begin
            rx_ph_q <= rx_ph_q + 1'b1;
         end
         if (!en_q) begin
            rx_st_q <= uss_pkg::RX_IDLE;
         end else begin
            case (rx_st_q)
               uss_pkg::RX_IDLE: if (!rxd_s) begin
                  rx_ph_q <= uss_pkg::PH_ZERO;
                  rx_st_q <= uss_pkg::RX_START;
               end
               uss_pkg::RX_START: if (tick && rx_ph_q == uss_pkg::PH_MID) begin
                  rx_ph_q <= uss_pkg::PH_ZERO;
                  rx_idx_q <= uss_pkg::IDX_ZERO;
                  rx_sh_q <= uss_pkg::BYTE_ZERO;
                  rx_st_q <= rxd_s ? uss_pkg::RX_IDLE : uss_pkg::RX_DATA;
               end
               uss_pkg::RX_DATA: if (rx_at_end) begin
                  rx_sh_q[rx_idx_q] <= rxd_s;
                  rx_idx_q <= rx_idx_q + 1'b1;
                  if (rx_idx_q == last_idx) begin
                     rx_st_q <= fmt_q.par_en ? uss_pkg::RX_PAR : uss_pkg::RX_STOP;
                  end
               end
               uss_pkg::RX_PAR: if (rx_at_end) begin
                  rx_pbad_q <= rxd_s ^ (^(rx_sh_q & data_mask)) ^ fmt_q.odd;
                  rx_st_q <= uss_pkg::RX_STOP;
               end
               default: if (rx_at_end) begin
                  rx_st_q <= uss_pkg::RX_IDLE;
               end
            endcase
         end
      end
   end

   // status view and read mux
   uss_pkg::uss_stat_s stat_w;
   assign stat_w = '{perr: perr_q, ovfr: ovfr_q, rx_wait: rxw_q,
      tx_busy: (tx_st_q != uss_pkg::TX_IDLE), thr_empty: !thr_full_q,
      dcd: pin_s_q[uss_pkg::PIN_DCD], dsr: pin_s_q[uss_pkg::PIN_DSR],
      cts: pin_s_q[uss_pkg::PIN_CTS]};
   wire [7:0] rd_mux = (ADDR == uss_pkg::ADDR_STAT) ? stat_w :
      (ADDR == uss_pkg::ADDR_DATA) ? rcr_q :
      (ADDR == uss_pkg::ADDR_DIV_LO) ? div_q[7:0] :
      (ADDR == uss_pkg::ADDR_DIV_HI) ? div_q[15:8] :
      (ADDR == uss_pkg::ADDR_IEN) ? {6'h00, ien_q} :
      (ADDR == uss_pkg::ADDR_MODE) ? {7'h00, en_q} : uss_pkg::BYTE_ZERO;
   wire irq_ev = (tx_done && ien_q[uss_pkg::IEN_TX]) || (rx_done && ien_q[uss_pkg::IEN_RX]);

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         hclk_prev_q <= 1'b1;
         fmt_q <= uss_pkg::FMT_RST;
         div_q <= uss_pkg::DIV_RST;
         ien_q <= 2'h0;
         en_q <= 1'b0;
         thr_q <= uss_pkg::BYTE_ZERO;
         thr_full_q <= 1'b0;
         rcr_q <= uss_pkg::BYTE_ZERO;
         rxw_q <= 1'b0;
         ovfr_q <= 1'b0;
         perr_q <= 1'b0;
         irq_q <= 1'b0;
         rdata_q <= uss_pkg::BYTE_ZERO;
         txd_q <= 1'b1;
      end else if (CE) begin
         hclk_prev_q <= pin_s_q[uss_pkg::PIN_HCLK];
         txd_q <= tx_bit;
         if (wr_fmt) fmt_q <= WDATA[5:0];
         if (wr_div_lo) div_q[7:0] <= WDATA;
         if (wr_div_hi) div_q[15:8] <= WDATA;
         if (wr_ien) ien_q <= WDATA[1:0];
         if (wr_mode) en_q <= WDATA[uss_pkg::MODE_EN];
         if (wr_thr) thr_q <= WDATA;
         if (wr_thr) thr_full_q <= 1'b1;
         else if (tx_done) thr_full_q <= 1'b0;
         if (RD) rdata_q <= rd_mux;
         if (rx_done) begin
            rcr_q <= rx_sh_q;
            ovfr_q <= !rxd_s || (rxw_q && !rd_rcr);
            perr_q <= fmt_q.par_en && rx_pbad_q;
         end
         if (rx_done) rxw_q <= 1'b1;
         else if (rd_rcr) rxw_q <= 1'b0;
         if (irq_ev) irq_q <= 1'b1;
         else if (rd_stat) irq_q <= 1'b0;
      end
   end

   assign RDATA = rdata_q;
   assign TXD = txd_q;
   assign IRQ = irq_q;

   // checks
   break_low_a: assert property (@(posedge CLK) disable iff (!RESETN)
      (CE && fmt_q.brk) |=> !TXD) else $error("break not driven low");
   status_read_a: assert property (@(posedge CLK) disable iff (!RESETN)
      (CE && rd_stat) |=> (RDATA[3] == !$past(thr_full_q)) && (RDATA[4] == ($past(tx_st_q) != uss_pkg::TX_IDLE)))
      else $error("status read shows wrong transmit state");
   data_count_a: assert property (@(posedge CLK) disable iff (!RESETN)
      (tx_st_q == uss_pkg::TX_DATA) |-> (tx_idx_q <= last_idx)) else $error("too many data bits");
   parity_gate_a: assert property (@(posedge CLK) disable iff (!RESETN)
      (tx_st_q == uss_pkg::TX_PAR) |-> fmt_q.par_en) else $error("parity bit sent while disabled");
   thr_fill_a: assert property (@(posedge CLK) disable iff (!RESETN)
      (CE && wr_thr) |=> thr_full_q && (thr_q == $past(WDATA))) else $error("holding register not marked full");
   tx_irq_a: assert property (@(posedge CLK) disable iff (!RESETN)
      (CE && tx_done && ien_q[uss_pkg::IEN_TX]) |=> IRQ && !thr_full_q) else $error("no irq on empty");
   irq_clear_a: assert property (@(posedge CLK) disable iff (!RESETN)
      (CE && rd_stat && !irq_ev) |=> !IRQ) else $error("status read left irq set");
   rx_wait_a: assert property (@(posedge CLK) disable iff (!RESETN)
      (CE && rx_done) |=> rxw_q && (rcr_q == $past(rx_sh_q))) else $error("received character lost");
   rx_irq_a: assert property (@(posedge CLK) disable iff (!RESETN)
      (CE && rx_done && ien_q[uss_pkg::IEN_RX]) |=> IRQ) else $error("no irq on receive");
   frame_err_a: assert property (@(posedge CLK) disable iff (!RESETN)
      (CE && rx_done && !rxd_s) |=> ovfr_q) else $error("framing fault not flagged");
   disabled_idle_a: assert property (@(posedge CLK) disable iff (!RESETN)
      (CE && !en_q) |=> (tx_st_q == uss_pkg::TX_IDLE) && (rx_st_q == uss_pkg::RX_IDLE))
      else $error("uart active while disabled");
endmodule : uss_uart
`default_nettype wire

// *** verif/uss_line_model.sv ***
// remote serial equipment: drives RXD and modem lines, captures TXD frames
// assumes the bench sets bit_ns to the bit time of the programmed divisor
`timescale 1ns/10ps
`default_nettype none
module uss_line_model (
   input wire logic txd,
   output logic rxd,
   output logic cts,
   output logic dsr,
   output logic dcd
);
   realtime bit_ns = 6400.0;
   initial begin
      rxd = 1'b1;
      {dcd, dsr, cts} = 3'h0;
   end
   task automatic lines(input logic [2:0] v);
      {dcd, dsr, cts} = v;
   endtask : lines
   // start, data lsb first, optional parity, stop, with optional faults
   task automatic send(input logic [7:0] d, input int nb, input logic pe, input logic odd,
                       input logic bad_par, input logic bad_stop);
      logic p;
      p = odd;
      #3;
      rxd = 1'b0;
      #(bit_ns);
      for (int i = 0; i < nb; i++) begin
         rxd = d[i];
         p = p ^ d[i];
         #(bit_ns);
      end
      if (pe) begin
         rxd = p ^ bad_par;
         #(bit_ns);
      end
      rxd = ~bad_stop;
      #(bit_ns);
      rxd = 1'b1;
      #(bit_ns);
   endtask : send
   // n bit slots from the start edge, sampled mid-bit; returns mid last slot
   task automatic grab(input int n, output logic [11:0] f);
      f = '0;
      @(negedge txd);
      #(bit_ns / 2);
      for (int i = 0; i < n; i++) begin
         f[i] = txd;
         if (i < n - 1) #(bit_ns);
      end
   endtask : grab
endmodule : uss_line_model
`default_nettype wire

// *** verif/uss_uart_tb.sv ***
// self-checking bench of the serial status/control uart
// assumes the line model on the far side and a 5 MHz host bit clock
`timescale 1ns/10ps
`default_nettype none
module uss_uart_tb;
   localparam int BIT_CYC = 256;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic ce = 1'b1;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic hclk = 1'b0;
   logic [7:0] rdata;
   wire logic rxd, cts, dsr, dcd, txd, irq;
   int errors = 0;
   int n_tests = 0;
   int cycles = 0;
   logic [5:0] fmts [6] = '{6'h00, 6'h0A, 6'h1C, 6'h26, 6'h3E, 6'h2E};
   logic [7:0] dats [6] = '{8'h15, 8'h2D, 8'h4B, 8'hA5, 8'h3C, 8'hE1};
   always #12.5 clk = ~clk;
   always #100 hclk = ~hclk;
   uss_uart dut (.CLK(clk), .RESETN(resetn), .CE(ce), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
      .RDATA(rdata), .HOST_CLK(hclk), .RXD(rxd), .CTS(cts), .DSR(dsr), .DCD(dcd), .TXD(txd), .IRQ(irq));
   uss_line_model line (.txd(txd), .rxd(rxd), .cts(cts), .dsr(dsr), .dcd(dcd));
   task automatic report_and_stop();
      if (errors == 0 && n_tests > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : report_and_stop
   always @(posedge clk) begin
      cycles++;
      if (cycles == 80000) begin
         errors++;
         report_and_stop();
      end
   end
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk(rdata & m, e & m);
   endtask : rd_chk
   task automatic wait_irq(input int n);
      for (int i = 0; i < n && irq !== 1'b1; i++) @(posedge clk);
      #1;
      chk(irq, 1'b1);
   endtask : wait_irq
   task automatic t_reset();
      chk({txd, irq}, 2'h2);
      rd_chk(uss_pkg::ADDR_DIV_LO, 8'hFF, 8'hFF);
      rd_chk(uss_pkg::ADDR_DIV_HI, 8'hFF, 8'hFF);
      rd_chk(uss_pkg::ADDR_IEN, 8'hFF, 8'h00);
      rd_chk(uss_pkg::ADDR_MODE, 8'hFF, 8'h00);
      rd_chk(8'h00, 8'hFF, 8'h00);
   endtask : t_reset
   task automatic t_lines();
      for (int v = 5; v > 1; v -= 3) begin
         line.lines(v[2:0]);
         repeat (4) @(posedge clk);
         rd_chk(uss_pkg::ADDR_STAT, 8'hFF, {5'h01, v[2:0]});
      end
   endtask : t_lines
   task automatic t_tx(input logic [5:0] f, input logic [7:0] d);
      int nd, n;
      logic [11:0] got, e;
      logic [7:0] m;
      nd = 5 + f[2:1];
      m = 8'hFF >> (8 - nd);
      e = {3'h0, d & m, 1'b0};
      n = nd + 1;
      if (f[3]) begin
         e[n] = f[4] ^ (^(d & m));
         n++;
      end
      e[n] = 1'b1;
      e[n + 1] = f[5];
      n += 1 + f[5];
      wr_reg(uss_pkg::ADDR_STAT, {2'h0, f});
      fork
         line.grab(n, got);
         wr_reg(uss_pkg::ADDR_DATA, d); // holding register seen full and busy first
      join
      chk(got, e);
      rd_chk(uss_pkg::ADDR_STAT, 8'h18, 8'h10);
      wait_irq(BIT_CYC);
      rd_chk(uss_pkg::ADDR_STAT, 8'h18, 8'h08);
      chk(irq, 1'b0);
   endtask : t_tx
   task automatic t_brk();
      wr_reg(uss_pkg::ADDR_STAT, 8'h01);
      repeat (4) @(posedge clk);
      chk(txd, 1'b0);
      wr_reg(uss_pkg::ADDR_STAT, 8'h00);
      repeat (4) @(posedge clk);
      chk(txd, 1'b1);
   endtask : t_brk
   task automatic t_rx(input logic [5:0] f, input logic [7:0] d, input logic bp, input logic bs,
                       input logic [7:0] fl);
      wr_reg(uss_pkg::ADDR_STAT, {2'h0, f});
      line.send(d, 5 + f[2:1], f[3], f[4], bp, bs);
      wait_irq(BIT_CYC);
      rd_chk(uss_pkg::ADDR_STAT, 8'hE0, fl | 8'h20);
      chk(irq, 1'b0);
      rd_chk(uss_pkg::ADDR_DATA, 8'hFF >> (3 - f[2:1]), d);
      rd_chk(uss_pkg::ADDR_STAT, 8'h20, 8'h00);
   endtask : t_rx
   task automatic t_rx_all();
      wr_reg(uss_pkg::ADDR_IEN, 8'h02);
      rd_chk(uss_pkg::ADDR_IEN, 8'hFF, 8'h02);
      t_rx(6'h1E, 8'h96, 1'b0, 1'b0, 8'h00);
      t_rx(6'h1E, 8'h96, 1'b1, 1'b0, 8'h80);
      t_rx(6'h06, 8'hC3, 1'b0, 1'b1, 8'h40);
      // low stop re-arms the receiver: let that frame end, then drop it
      repeat (12 * BIT_CYC) @(posedge clk);
      @(posedge clk);
      addr <= uss_pkg::ADDR_DATA;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      line.send(8'h11, 8, 1'b0, 1'b0, 1'b0, 1'b0);
      line.send(8'h22, 8, 1'b0, 1'b0, 1'b0, 1'b0);
      rd_chk(uss_pkg::ADDR_STAT, 8'h40, 8'h40);
      rd_chk(uss_pkg::ADDR_DATA, 8'hFF, 8'h22);
      t_rx(6'h02, 8'h2B, 1'b0, 1'b0, 8'h00);
   endtask : t_rx_all
   task automatic t_div();
      wr_reg(uss_pkg::ADDR_IEN, 8'h01);
      wr_reg(uss_pkg::ADDR_DIV_LO, 8'hFE);
      rd_chk(uss_pkg::ADDR_DIV_LO, 8'hFF, 8'hFE);
      line.bit_ns = 9600.0;
      t_tx(6'h06, 8'h5A);
   endtask : t_div
   task automatic t_mode();
      int hi;
      hi = 0;
      wr_reg(uss_pkg::ADDR_MODE, 8'h00);
      wr_reg(uss_pkg::ADDR_DATA, 8'h00);
      repeat (BIT_CYC) begin
         @(posedge clk);
         if (txd === 1'b1) hi++;
      end
      chk(16'(hi), 16'(BIT_CYC));
      chk(irq, 1'b0);
   endtask : t_mode
   task automatic t_ce();
      @(posedge clk);
      ce <= 1'b0;
      wr_reg(uss_pkg::ADDR_IEN, 8'h03);
      ce <= 1'b1;
      rd_chk(uss_pkg::ADDR_IEN, 8'hFF, 8'h00);
   endtask : t_ce
   initial begin
      repeat (3) @(posedge clk);
      resetn <= 1'b1;
      t_reset();
      t_lines();
      t_ce();
      wr_reg(uss_pkg::ADDR_MODE, 8'h01);
      wr_reg(uss_pkg::ADDR_IEN, 8'h01);
      for (int i = 0; i < 6; i++) t_tx(fmts[i], dats[i]);
      t_brk();
      t_rx_all();
      t_div();
      t_mode();
      report_and_stop();
   end
endmodule : uss_uart_tb
`default_nettype wire
